// file: logic/aets_map.svh
`ifndef AETS_MAP_SVH
`define AETS_MAP_SVH

// register indices and byte addresses (byte address is four times the index)
`define AETS_IDX_CTRL        16'h1D29
`define AETS_IDX_STAT        16'h1D2A
`define AETS_ADDR_CTRL       (`AETS_IDX_CTRL << 2)
`define AETS_ADDR_STAT       (`AETS_IDX_STAT << 2)

// control register fields
`define AETS_CTRL_ERROR_SELECT_A_LSB   4
`define AETS_CTRL_SOI_BIT    3
`define AETS_CTRL_TMD_LSB    0
`define AETS_CTRL_RESET      8'h00

// status register fields
`define AETS_STAT_AOV_BIT    7
`define AETS_STAT_ABOVE_UPPER_FLAG_BIT   6
`define AETS_STAT_BELOW_LOWER_FLAG_BIT   5
`define AETS_STAT_COMPUTE_UPDATED_BIT   4
`define AETS_STAT_STG_LSB    0
`define AETS_STAT_RESET      8'h00

// stage codes
`define AETS_STG_IDLE        3'h0
`define AETS_STG_SUSPEND     3'h4

// error selector codes
`define AETS_ERROR_SELECT_A_RES_PREV   3'h0
`define AETS_ERROR_SELECT_A_RES_SET    3'h1
`define AETS_ERROR_SELECT_A_RES_FLT    3'h2
`define AETS_ERROR_SELECT_A_PREV_FLT   3'h4
`define AETS_ERROR_SELECT_A_FLT_SET    3'h5

// threshold interrupt codes
`define AETS_TMD_NEVER       3'h0
`define AETS_TMD_BELOW       3'h1
`define AETS_TMD_AT_LEAST    3'h2
`define AETS_TMD_BETWEEN     3'h3
`define AETS_TMD_OUTSIDE     3'h4
`define AETS_TMD_AT_MOST_UP  3'h5
`define AETS_TMD_ABOVE       3'h6
`define AETS_TMD_ALWAYS      3'h7

`endif

// file: logic/aets_pkg.sv
package aets_pkg;

    localparam int DW = 16;

    // avalon request from the master
    typedef struct packed {
        logic        read;
        logic        write;
        logic [15:0] address;
        logic [31:0] writedata;
    } aets_bus_req_t;

    // sample values delivered by the converter datapath
    typedef struct packed {
        logic signed [DW-1:0] conversion_result;
        logic signed [DW-1:0] filtered_value;
        logic signed [DW-1:0] setpoint_value;
        logic signed [DW-1:0] upper_threshold;
        logic signed [DW-1:0] lower_threshold;
    } aets_sample_t;

    // sequencer and mode inputs from the rest of the converter
    typedef struct packed {
        logic       conv_start;       // pulse: a conversion begins
        logic       conv_done;        // pulse: a conversion result is ready
        logic [1:0] seq_phase;        // 0 idle, 1 precharge, 2 acquisition, 3 conversion
        logic       double_sample_enable;
        logic       previous_source_select;
        logic       repeat_mode;
        logic       acc_overflow;     // pulse: accumulator or filter overflowed
        logic       acc_updated;      // pulse: accumulator or filter updated
        logic       acc_clear;        // pulse: accumulator clear command
    } aets_conv_t;

    // whole state of the block
    typedef struct packed {
        logic                 waitrequest;
        logic [31:0]          readdata;
        logic [2:0]           error_select_a;
        logic                 stop_on_threshold_hit;
        logic [2:0]           threshold_irq_select;
        logic                 overflow_flag;
        logic                 above_upper_flag;
        logic                 below_lower_flag;
        logic                 compute_updated;
        logic                 second_sample;
        logic                 suspended;
        logic signed [DW-1:0] error_value;
        logic signed [DW-1:0] previous_sample;
        logic                 threshold_irq;
        logic                 go_clear;
    } aets_state_t;

endpackage : aets_pkg

// file: logic/aets_top.sv
// Our own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`include "aets_map.svh"

module aets_top
(
    // clock and reset
    input  wire logic                          clk_sys,
    input  wire logic                          rst,
    // avalon-mm slave
    input  wire aets_pkg::aets_bus_req_t       bus_req,
    output logic [31:0]                        readdata,
    output logic                               waitrequest,
    // converter datapath
    input  wire aets_pkg::aets_sample_t        sample,
    input  wire aets_pkg::aets_conv_t          conv,
    // results
    output logic signed [aets_pkg::DW-1:0]     error_value,
    output logic signed [aets_pkg::DW-1:0]     previous_sample,
    output logic                               threshold_irq,
    output logic                               go_clear
);
    import aets_pkg::*;

    aets_state_t st;
    aets_state_t next_st;

    // threshold interrupt decision for one selector code
    function automatic logic irq_hit(input logic [2:0] code, input logic gt_up,
                                     input logic lt_low, input logic gt_low,
                                     input logic lt_up);
        logic hit;
        hit = 1'b0;
        case (code)
            `AETS_TMD_ALWAYS:     hit = 1'b1;
            `AETS_TMD_ABOVE:      hit = gt_up;
            `AETS_TMD_AT_MOST_UP: hit = !gt_up;
            `AETS_TMD_OUTSIDE:    hit = lt_low | gt_up;
            `AETS_TMD_BETWEEN:    hit = gt_low & lt_up;
            `AETS_TMD_AT_LEAST:   hit = !lt_low;
            `AETS_TMD_BELOW:      hit = lt_low;
            `AETS_TMD_NEVER:      hit = 1'b0;
            default:              hit = 1'b0;
        endcase
        return hit;
    endfunction : irq_hit

    // wide signed operands for the error arithmetic
    logic signed [DW+1:0] res_w;
    logic signed [DW+1:0] prev_w;
    logic signed [DW+1:0] flt_w;
    logic signed [DW+1:0] set_w;
    logic signed [DW+1:0] diff_w;
    logic signed [DW+1:0] err_w;
    logic signed [DW-1:0] err_n;
    logic                 err_ovf;
    logic                 do_compute;
    logic                 gt_up;
    logic                 lt_low;
    logic                 gt_low;
    logic                 lt_up;
    logic                 hit;
    logic [2:0]           stage;
    logic                 wr_ctrl;
    logic                 wr_stat;

    // sign-extend the operands
    assign res_w  = (DW+2)'(sample.conversion_result);
    assign prev_w = (DW+2)'(st.previous_sample);
    assign flt_w  = (DW+2)'(sample.filtered_value);
    assign set_w  = (DW+2)'(sample.setpoint_value);
    assign diff_w = conv.double_sample_enable ? (res_w - prev_w) : res_w;

    // error arithmetic by selector
    always_comb
    begin
        case (st.error_select_a)
            `AETS_ERROR_SELECT_A_FLT_SET:  err_w = flt_w - set_w;
            `AETS_ERROR_SELECT_A_PREV_FLT: err_w = prev_w - flt_w;
            `AETS_ERROR_SELECT_A_RES_FLT:  err_w = diff_w - flt_w;
            `AETS_ERROR_SELECT_A_RES_SET:  err_w = diff_w - set_w;
            `AETS_ERROR_SELECT_A_RES_PREV: err_w = res_w - prev_w;
            default:             err_w = '0;
        endcase
    end

    assign err_n   = err_w[DW-1:0];
    assign err_ovf = (err_w != (DW+2)'(err_n));

    // compute after each conversion, or after the second of a pair
    assign do_compute = conv.conv_done & (!conv.double_sample_enable | st.second_sample);

    // signed comparisons of the new error
    assign gt_up  = err_n > sample.upper_threshold;
    assign lt_low = err_n < sample.lower_threshold;
    assign gt_low = err_n > sample.lower_threshold;
    assign lt_up  = err_n < sample.upper_threshold;
    assign hit    = irq_hit(st.threshold_irq_select, gt_up, lt_low, gt_low, lt_up);

    // stage code from the sequencer phase and pair position
    // phase comes from this clock domain; no resynchronisation added
    always_comb
    begin
        if (conv.seq_phase == 2'h0)
            stage = st.suspended ? `AETS_STG_SUSPEND : `AETS_STG_IDLE;
        else
            stage = {st.second_sample, conv.seq_phase};
    end

    // write strobes at the edge where the request is accepted
    assign wr_ctrl = bus_req.write & !st.waitrequest & (bus_req.address == `AETS_ADDR_CTRL);
    assign wr_stat = bus_req.write & !st.waitrequest & (bus_req.address == `AETS_ADDR_STAT);

    // next-state logic
    always_comb
    begin
        next_st               = st;
        next_st.threshold_irq = 1'b0;
        next_st.go_clear      = 1'b0;

        // bus handshake: one wait cycle then accept
        next_st.waitrequest = !((bus_req.read | bus_req.write) & st.waitrequest);
        if (bus_req.read & st.waitrequest)
        begin
            next_st.readdata = 32'h0000_0000;
            if (bus_req.address == `AETS_ADDR_CTRL)
                next_st.readdata[7:0] = {1'b0, st.error_select_a,
                                         st.stop_on_threshold_hit, st.threshold_irq_select};
            else if (bus_req.address == `AETS_ADDR_STAT)
                next_st.readdata[7:0] = {st.overflow_flag, st.above_upper_flag,
                                         st.below_lower_flag, st.compute_updated, 1'b0,
                                         stage};
        end

        // software writes
        if (wr_ctrl)
        begin
            next_st.error_select_a        = bus_req.writedata[`AETS_CTRL_ERROR_SELECT_A_LSB +: 3];
            next_st.stop_on_threshold_hit = bus_req.writedata[`AETS_CTRL_SOI_BIT];
            next_st.threshold_irq_select  = bus_req.writedata[`AETS_CTRL_TMD_LSB +: 3];
        end
        // software clears the overflow flag by writing zero
        if (wr_stat & !bus_req.writedata[`AETS_STAT_AOV_BIT])
            next_st.overflow_flag = 1'b0;
        if (wr_stat & !bus_req.writedata[`AETS_STAT_COMPUTE_UPDATED_BIT] && stage != `AETS_STG_SUSPEND)
            next_st.compute_updated = 1'b0;
        // hardware clear by accumulator clear command
        if (conv.acc_clear)
            next_st.overflow_flag = 1'b0;

        // previous sample loaded at conversion start
        if (conv.conv_start)
        begin
            next_st.previous_sample = conv.previous_source_select ? sample.filtered_value
                                                                  : sample.conversion_result;
            next_st.suspended = 1'b0;
        end

        // pair tracking on each finished conversion
        if (conv.conv_done)
        begin
            if (conv.double_sample_enable & !st.second_sample)
            begin
                next_st.second_sample = 1'b1;
                // waits for the second trigger only outside repeat mode
                next_st.suspended = !conv.repeat_mode;
            end
            else
            begin
                next_st.second_sample = 1'b0;
                next_st.suspended     = 1'b0;
            end
        end

        // error refreshed only when the computation runs
        if (do_compute)
        begin
            next_st.error_value = err_n;
            next_st.above_upper_flag = gt_up;
            next_st.below_lower_flag = lt_low;
            next_st.threshold_irq = hit;
            // stop on hit in repeat mode only
            if (conv.repeat_mode & st.stop_on_threshold_hit & hit)
            begin
                next_st.go_clear              = 1'b1;
                next_st.stop_on_threshold_hit = 1'b0;
            end
            // without the stop bit the convert bit is left alone
        end

        // overflow set wins over any clear
        if (conv.acc_overflow | (do_compute & err_ovf))
            next_st.overflow_flag = 1'b1;
        // update marker set wins over any clear
        if (conv.acc_updated | do_compute | conv.acc_overflow)
            next_st.compute_updated = 1'b1;
    end

    // state register
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            st             <= '0;
            st.waitrequest <= 1'b1;
        end
        else
            st <= next_st;
    end

    // outputs straight from the state
    assign readdata        = st.readdata;
    assign waitrequest     = st.waitrequest;
    assign error_value     = st.error_value;
    assign previous_sample = st.previous_sample;
    assign threshold_irq   = st.threshold_irq;
    assign go_clear        = st.go_clear;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    sequence s_compute;
        conv.conv_done && (!conv.double_sample_enable || st.second_sample);
    endsequence

    sequence s_stop_hit;
        s_compute ##0 (conv.repeat_mode && st.stop_on_threshold_hit && hit);
    endsequence

    a_stop_clears_go: assert property (s_stop_hit |=> go_clear && !st.stop_on_threshold_hit)
        else $error("convert bit not cleared on threshold hit");
    a_no_stop_keeps: assert property (!st.stop_on_threshold_hit |=> !go_clear)
        else $error("convert bit cleared without stop bit");
    a_single_mode_go: assert property (!conv.repeat_mode |=> !go_clear)
        else $error("convert bit cleared outside repeat mode");
    a_upper_flag_tracks: assert property (s_compute |=>
                         (st.above_upper_flag == (error_value > $past(sample.upper_threshold))))
        else $error("above-upper flag wrong");
    a_lower_flag_tracks: assert property (s_compute |=>
                         (st.below_lower_flag == (error_value < $past(sample.lower_threshold))))
        else $error("below-lower flag wrong");
    a_never_irq: assert property (st.threshold_irq_select == `AETS_TMD_NEVER |=> !threshold_irq)
        else $error("interrupt with never code");
    a_always_irq: assert property (s_compute ##0 st.threshold_irq_select == `AETS_TMD_ALWAYS
                                   |=> threshold_irq)
        else $error("missing interrupt with always code");
    a_first_no_update: assert property (conv.conv_done && conv.double_sample_enable
                                        && !st.second_sample |=> $stable(error_value))
        else $error("error updated after first sample of pair");
    a_prev_load: assert property (conv.conv_start && !conv.previous_source_select
                                  |=> previous_sample == $past(sample.conversion_result))
        else $error("previous sample not loaded from result");
    a_ovf_sticky: assert property (conv.acc_overflow |=> st.overflow_flag)
        else $error("overflow flag not set");
    a_compute_updated_held: assert property (stage == `AETS_STG_SUSPEND && wr_stat && st.compute_updated
                                  |=> st.compute_updated)
        else $error("compute flag cleared while suspended");
    a_wait_answer: assert property ((bus_req.read || bus_req.write) && waitrequest
                                    |=> !waitrequest ##1 waitrequest)
        else $error("bus answer timing wrong");

endmodule : aets_top

// file: dv/tb_adc_error_threshold_status.sv
`timescale 1ns/1ns
`include "aets_map.svh"

module tb_adc_error_threshold_status;
    import aets_pkg::*;

    localparam logic [15:0] A_CTRL = `AETS_ADDR_CTRL;
    localparam logic [15:0] A_STAT = `AETS_ADDR_STAT;

    // design connections
    logic                 clk_sys;
    logic                 rst;
    aets_bus_req_t        bus_req;
    logic [31:0]          readdata;
    logic                 waitrequest;
    aets_sample_t         sample;
    aets_conv_t           conv;
    logic signed [DW-1:0] error_value;
    logic signed [DW-1:0] previous_sample;
    logic                 threshold_irq;
    logic                 go_clear;
    // bench bookkeeping
    int                   bad_count;
    int                   checks;
    int                   cycles;
    logic signed [DW-1:0] prev_m;
    logic [7:0]           ctrl_m;
    logic [31:0]          rd;
    logic [2:0]           sels [7] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h3, 3'h7};

    aets_top uut
    (
        .clk_sys(clk_sys), .rst(rst), .bus_req(bus_req), .readdata(readdata),
        .waitrequest(waitrequest), .sample(sample), .conv(conv),
        .error_value(error_value), .previous_sample(previous_sample),
        .threshold_irq(threshold_irq), .go_clear(go_clear)
    );

    // system clock, 8 ns period
    initial
    begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    // counts and verdict, then stop
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : summarize

    // hang guard
    always @(posedge clk_sys)
    begin
        cycles = cycles + 1;
        if (cycles == 10000)
        begin
            bad_count = bad_count + 1;
            summarize();
        end
    end

    // one comparison
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks = checks + 1;
        if (seen !== exp)
        begin
            bad_count = bad_count + 1;
            $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : chk

    // avalon transfer: hold until waitrequest is sampled low
    task automatic bus_xfer(input logic wr, input logic [15:0] a, input logic [7:0] d,
                            output logic [31:0] rdata);
        int n;
        n = 0;
        @(posedge clk_sys);
        bus_req.read      <= ~wr;
        bus_req.write     <= wr;
        bus_req.address   <= a;
        bus_req.writedata <= {24'h00_0000, d};
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (waitrequest !== 1'b0);
        // one wait cycle before the answer
        chk(n, 32'h0000_0002, "wait states");
        rdata = readdata;
        bus_req.read  <= 1'b0;
        bus_req.write <= 1'b0;
    endtask : bus_xfer

    // random signed sample value well inside the range
    function automatic logic signed [15:0] rnd();
        return 16'(int'($urandom_range(16000)) - 8000);
    endfunction : rnd

    // expected error for a selector
    function automatic logic signed [15:0] exp_err(input logic [2:0] s, input logic ds,
        input logic signed [15:0] r, f, p, t);
        logic signed [15:0] d;
        d = ds ? r - p : r;
        case (s)
            3'h0: return r - p;
            3'h1: return d - t;
            3'h2: return d - f;
            3'h4: return p - f;
            3'h5: return f - t;
            default: return 16'h0000;
        endcase
    endfunction : exp_err

    // expected threshold request for a mode
    function automatic logic exp_irq(input logic [2:0] m, input logic signed [15:0] e, u, l);
        case (m)
            3'h7: return 1'b1;
            3'h6: return e > u;
            3'h5: return e <= u;
            3'h4: return e < l || e > u;
            3'h3: return e > l && e < u;
            3'h2: return e >= l;
            3'h1: return e < l;
            default: return 1'b0;
        endcase
    endfunction : exp_irq

    // one conversion: start loads previous sample, done triggers the compute_updated except on the first sample of a pair
    task automatic convert(input logic signed [15:0] nr, nf, input logic [1:0] ph);
        @(posedge clk_sys);
        conv.conv_start <= 1'b1;
        conv.seq_phase  <= ph;
        prev_m = conv.previous_source_select ? sample.filtered_value : sample.conversion_result;
        @(posedge clk_sys);
        conv.conv_start          <= 1'b0;
        sample.conversion_result <= nr;
        sample.filtered_value    <= nf;
        @(posedge clk_sys);
        chk(previous_sample, prev_m, "previous");
        conv.conv_done <= 1'b1;
        conv.seq_phase <= 2'd0;
        @(posedge clk_sys);
        conv.conv_done <= 1'b0;
        // results launched by the done edge are read at the next edge
        @(posedge clk_sys);
    endtask : convert

    // compare outputs of a computing conversion
    task automatic check_error_select_a(input logic ds);
        logic signed [15:0] e;
        logic               h;
        e = exp_err(ctrl_m[6:4], ds, sample.conversion_result, sample.filtered_value,
                    prev_m, sample.setpoint_value);
        h = exp_irq(ctrl_m[2:0], e, sample.upper_threshold, sample.lower_threshold);
        chk(error_value, e, "error");
        chk(threshold_irq, h, "irq");
        chk(go_clear, h & conv.repeat_mode & ctrl_m[3], "stop");
        bus_xfer(1'b0, A_STAT, 8'h00, rd);
        chk(rd[6:5], {e > sample.upper_threshold, e < sample.lower_threshold}, "flags");
        if (h & conv.repeat_mode & ctrl_m[3])
        begin
            ctrl_m[3] = 1'b0;
            bus_xfer(1'b0, A_CTRL, 8'h00, rd);
            chk(rd, {24'h00_0000, ctrl_m}, "stop bit");
        end
    endtask : check_error_select_a

    // main sequence
    initial
    begin
        logic [2:0] s;
        logic       ds;
        void'($urandom(32'hf1ec));
        rst = 1'b1;
        bus_req = '0;
        sample = '0;
        conv = '0;
        bad_count = 0;
        checks = 0;
        cycles = 0;
        ctrl_m = 8'h00;
        prev_m = '0;
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        // reset values, unmapped place, unused bit
        bus_xfer(1'b0, A_CTRL, 8'h00, rd);
        chk(rd, 32'h0000_0000, "ctrl reset");
        bus_xfer(1'b0, A_STAT, 8'h00, rd);
        chk(rd, 32'h0000_0000, "stat reset");
        bus_xfer(1'b0, 16'h0010, 8'h00, rd);
        chk(rd, 32'h0000_0000, "unmapped");
        bus_xfer(1'b1, A_CTRL, 8'hff, rd);
        bus_xfer(1'b0, A_CTRL, 8'h00, rd);
        chk(rd, 32'h0000_007f, "ctrl rw");
        // stage field follows the sequencer phase
        for (int ph = 0; ph < 4; ph++)
        begin
            conv.seq_phase <= 2'(ph);
            bus_xfer(1'b0, A_STAT, 8'h00, rd);
            chk(rd[2:0], 3'(ph), "stage");
        end
        conv.seq_phase <= 2'd0;
        // overflow sets both bits, software zero clears them
        conv.acc_overflow <= 1'b1;
        @(posedge clk_sys);
        conv.acc_overflow <= 1'b0;
        bus_xfer(1'b0, A_STAT, 8'h00, rd);
        chk(rd[7:4], 4'h9, "overflow set");
        // overflow in the same cycle as an accumulator clear wins
        conv.acc_overflow <= 1'b1;
        conv.acc_clear    <= 1'b1;
        @(posedge clk_sys);
        conv.acc_overflow <= 1'b0;
        conv.acc_clear    <= 1'b0;
        bus_xfer(1'b0, A_STAT, 8'h00, rd);
        chk(rd[7], 1'b1, "overflow wins");
        // accumulator clear alone drops the overflow flag
        conv.acc_clear <= 1'b1;
        @(posedge clk_sys);
        conv.acc_clear <= 1'b0;
        bus_xfer(1'b0, A_STAT, 8'h00, rd);
        chk(rd[7:4], 4'h1, "acc clear");
        bus_xfer(1'b1, A_STAT, 8'h00, rd);
        bus_xfer(1'b0, A_STAT, 8'h00, rd);
        chk(rd[7:4], 4'h0, "overflow clear");
        // result minus setpoint leaving the signed range
        ctrl_m = 8'h17;
        bus_xfer(1'b1, A_CTRL, ctrl_m, rd);
        sample.setpoint_value <= 16'sh8000;
        convert(16'sh7fff, 16'sh0000, 2'd3);
        check_error_select_a(1'b0);
        chk(rd[7], 1'b1, "error overflow");
        // pair waiting for its second sample
        conv.double_sample_enable <= 1'b1;
        conv.acc_updated          <= 1'b1;
        @(posedge clk_sys);
        conv.acc_updated <= 1'b0;
        convert(16'sh0100, 16'sh0020, 2'd3);
        chk(threshold_irq, 1'b0, "first of pair");
        bus_xfer(1'b0, A_STAT, 8'h00, rd);
        chk(rd[2:0], 3'h4, "suspended");
        bus_xfer(1'b1, A_STAT, 8'h00, rd);
        bus_xfer(1'b0, A_STAT, 8'h00, rd);
        chk(rd[4], 1'b1, "compute_updated kept");
        conv.seq_phase <= 2'd1;
        bus_xfer(1'b0, A_STAT, 8'h00, rd);
        chk(rd[2:0], 3'h5, "second stage");
        convert(16'sh0180, 16'sh0020, 2'd3);
        check_error_select_a(1'b1);
        // random selectors, modes and samples
        for (int i = 0; i < 60; i++)
        begin
            s  = sels[$urandom_range(6)];
            ds = 1'($urandom_range(1));
            ctrl_m = {1'b0, s, 1'($urandom_range(1)), 3'($urandom_range(7))};
            bus_xfer(1'b1, A_CTRL, ctrl_m, rd);
            conv.double_sample_enable   <= ds;
            conv.repeat_mode            <= 1'($urandom_range(1));
            conv.previous_source_select <= 1'($urandom_range(1));
            sample.setpoint_value       <= rnd();
            sample.upper_threshold      <= rnd();
            sample.lower_threshold      <= rnd();
            if (ds)
            begin
                convert(rnd(), rnd(), 2'd3);
                chk(threshold_irq, 1'b0, "first of pair");
            end
            convert(rnd(), rnd(), 2'd3);
            check_error_select_a(ds);
        end
        // reset in mid-run brings both registers back to zero
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        bus_xfer(1'b0, A_CTRL, 8'h00, rd);
        chk(rd, 32'h0000_0000, "ctrl after reset");
        bus_xfer(1'b0, A_STAT, 8'h00, rd);
        chk(rd, 32'h0000_0000, "stat after reset");
        summarize();
    end

endmodule : tb_adc_error_threshold_status
